/* File: tb/handler_model.sv */
// handler model: samples the lines every cycle and pulses got_ff once the done strobe falls
module handler_model (
  input wire logic clock, // bench clock
  input wire logic measure_done_n, // done strobe
  input wire logic [13:0] lines, // all sort and limit lines
  output logic [13:0] seen_ff, // lines as read
  output logic got_ff // one-cycle read pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic done_ff;
  always_ff @(posedge clock) begin
    done_ff <= measure_done_n;
    got_ff <= done_ff && !measure_done_n; // analog strobe alone never reads
    seen_ff <= lines;
  end
endmodule

/* File: tb/sort_handler_monitor.sv */
// assertions on the handler output ports
module sort_handler_monitor
  import sort_handler_pkg::*;
(
  input wire logic clock, resetn, meas_start, analog_done, result_valid, last_point,
  input wire logic circuit_open, key_lock_n, alarm_n, analog_done_n, measure_done_n, aux_line_n,
  input wire cmp_mode_t mode,
  input wire logic [7:0] keys_accepted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  alarm_follow_a: assert property (circuit_open |=> !alarm_n) else $error("alarm");
  key_lock_a: assert property (!key_lock_n |=> keys_accepted == 8'h00) else $error("lock");
  bin_done_a: assert property (mode == MODE_BIN && result_valid && !meas_start |=> !measure_done_n) else $error("bin");
  start_clear_a: assert property (meas_start |=> measure_done_n && analog_done_n) else $error("clear");
  seq_index_a: assert property (mode == MODE_SWEEP_SEQ && !last_point && analog_done_n |=> analog_done_n) else $error("idx");
  seq_done_a: assert property (mode == MODE_SWEEP_SEQ && result_valid && last_point && !meas_start |=> !measure_done_n) else $error("seq");
  step_strobe_a: assert property (mode == MODE_SWEEP_STEP && analog_done && result_valid && !meas_start |=> !analog_done_n && !measure_done_n) else $error("step");
  sweep_hold_a: assert property (mode != MODE_BIN && !(result_valid && last_point) |=> $stable(aux_line_n)) else $error("hold");
endmodule
bind sorting_handler_output_logic sort_handler_monitor mon (.*);

/* File: tb/sorting_handler_output_logic_tb.sv */
// self-checking bench for the handler output logic
module sorting_handler_output_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sort_handler_pkg::*;
  logic clock = 0, resetn = 0, meas_start = 0, analog_done = 0, result_valid = 0, last_point = 0, point_fail = 0;
  logic bin_out = 0, bin_aux = 0, primary_above = 0, primary_below = 0, secondary_above = 0, secondary_below = 0;
  logic circuit_open = 0, key_lock_n = 1, alarm_n, out_line_n, aux_line_n, primary_high_n, primary_low_n;
  logic secondary_reject_n, analog_done_n, measure_done_n, got_ff;
  logic [3:0] point_index = 4'h0;
  logic [7:0] panel_keys = 8'h00, keys_accepted;
  logic [8:0] bin_hit = 9'h000, sort_line_n;
  logic [13:0] seen_ff, last, q[$];
  logic [9:0] rnd;
  logic [8:0] kq[$];
  cmp_mode_t mode = MODE_BIN;
  int err_count = 0, checks_done = 0;
  always #2.5 clock = ~clock;
  sorting_handler_output_logic DUT (.*);
  handler_model partner (.clock(clock), .measure_done_n(measure_done_n), .seen_ff(seen_ff), .got_ff(got_ff),
    .lines({aux_line_n, out_line_n, sort_line_n, primary_high_n, primary_low_n, secondary_reject_n}));
  always @(posedge clock) begin
    rnd = 10'($urandom);
    panel_keys <= rnd[7:0];
    key_lock_n <= rnd[8];
    circuit_open <= rnd[9];
    if (resetn) kq.push_back({~rnd[9], rnd[8] ? rnd[7:0] : 8'h00});
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [13:0] act);
    logic [13:0] exp;
    exp = q.size() ? q.pop_front() : 14'h0000;
    checks_done++;
    if (act !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, act, exp);
    end
  endtask
  task chk_pins(input logic [8:0] act, input logic [8:0] exp);
    checks_done++;
    if (act !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, act, exp);
    end
  endtask
  // outputs settle one edge after the drive; one note always stays queued for the next edge
  always @(negedge clock) if (kq.size() > 1) chk_pins({alarm_n, keys_accepted}, kq.pop_front());
  // the handler only reads lines after the done strobe, so each strobe pops one note
  always @(posedge clock) if (got_ff === 1'b1) chk(seen_ff);
  // one task per measurement: bin mode when n is 1, else a ten-point sweep
  task meas(input cmp_mode_t m, input int n);
    logic [9:0] f;
    logic [3:0] b;
    f = 10'($urandom);
    b = 4'($urandom_range(8));
    mode <= m;
    meas_start <= 1'b1;
    @(posedge clock);
    meas_start <= 1'b0;
    if (n == 1) last = {~f[5], ~f[4], ~(9'h001 << b), ~f[0], ~f[1], ~(f[2] | f[3])};
    q.push_back(m == MODE_SWEEP_SEQ ? {~|f, ~f[9], ~f[8:0], 3'b111} : last);
    if (n > 1) last = {~|f, ~f[9], ~f[8:0], 3'b111}; // stepped lines move only at sweep end
    bin_hit <= 9'h001 << b;
    {bin_aux, bin_out, secondary_below, secondary_above, primary_below, primary_above} <= f[5:0];
    for (int i = 0; i < n; i++) begin
      {result_valid, analog_done, point_index, last_point, point_fail} <= {2'b11, 4'(i), i == n - 1, f[i]};
      @(posedge clock);
    end
    {result_valid, analog_done, last_point} <= 3'b000;
    repeat (5) @(posedge clock);
    $display("test done mode %0d", m);
  endtask
  initial begin
    void'($urandom(82));
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    repeat (4) meas(MODE_BIN, 1);
    meas(MODE_SWEEP_SEQ, 10);
    meas(MODE_SWEEP_STEP, 10);
    meas(MODE_SWEEP_STEP, 10);
    meas(MODE_SWEEP_SEQ, 10);
    end_sim;
  end
  initial begin
    #5000;
    err_count++;
    end_sim;
  end
endmodule

/* File: verilog/sort_handler_params.svh */
// constants for the sorting handler output logic
`ifndef SORT_HANDLER_PARAMS_SVH
`define SORT_HANDLER_PARAMS_SVH
`define SH_NUM_BINS 9
`define SH_NUM_POINTS 10
`define SH_POINT_W 4
`define SH_LINE_IDLE 1'b1
`define SH_LINE_ACTIVE 1'b0
`endif

/* File: verilog/sort_handler_pkg.sv */
// types for the sorting handler output logic
package sort_handler_pkg;
  typedef enum logic [1:0] {
    MODE_BIN,
    MODE_SWEEP_SEQ,
    MODE_SWEEP_STEP
  } cmp_mode_t;
endpackage

/* File: verilog/sorting_handler_output_logic.sv */
// handler output logic: sort lines, control strobes and key lock
`include "sort_handler_params.svh"
// Notes on behaviour
// [R1] all handler outputs are active low
// [R2] primary high/low lines in bin mode
// [R3] secondary reject when outside its window
// [R4] key lock blocks front panel keys
// [R5] alarm on interrupted measurement circuit
// [R6] analog done once analog measurement finishes
// [R7] handler waits for measure done
// [R8] measure done after data and comparison valid
// [R9] line meaning follows comparator mode
// [R10] sweep: lines per point, aux overall
// [R11] bins map points 1-9, out point 10
// [R12] sweep lines update only at sweep end
// [R13] sequential: analog done after last point
// [R14] sequential: measure done after whole sweep
// [R15] stepped: analog done every point; the held level shows one falling edge per list
// [R16] stepped: measure done every step; the held level shows one falling edge per list
// [R17] strobes clear at next start, lines hold
module sorting_handler_output_logic
  import sort_handler_pkg::*;
#(
  parameter int NUM_BINS = `SH_NUM_BINS,
  parameter int NUM_POINTS = `SH_NUM_POINTS
) (
  input wire logic clock, // 200 MHz
  input wire logic resetn, // async reset, low active
  input wire cmp_mode_t mode, // active comparator mode
  input wire logic meas_start, // pulse: measurement begins
  input wire logic analog_done, // pulse: analog part of one point done
  input wire logic result_valid, // pulse: data and comparison of one point valid
  input wire logic [`SH_POINT_W-1:0] point_index, // sweep point 0..9 of this result
  input wire logic last_point, // this point ends the sweep
  input wire logic [NUM_BINS-1:0] bin_hit, // bin mode: one-hot bin of result
  input wire logic bin_out, // bin mode: no bin matched
  input wire logic bin_aux, // bin mode: auxiliary bin
  input wire logic primary_above, // primary result over upper limit
  input wire logic primary_below, // primary result under lower limit
  input wire logic secondary_above, // secondary over its high limit
  input wire logic secondary_below, // secondary under its low limit
  input wire logic point_fail, // sweep point out of limit
  input wire logic circuit_open, // measurement circuit interrupted
  input wire logic key_lock_n, // handler key lock, low active
  input wire logic [7:0] panel_keys, // raw front panel keys
  output logic [NUM_BINS-1:0] sort_line_n, // bin / point lines
  output logic out_line_n, // out / point ten
  output logic aux_line_n, // aux / overall fail
  output logic primary_high_n, // primary over limit
  output logic primary_low_n, // primary under limit
  output logic secondary_reject_n, // secondary out of window
  output logic alarm_n, // circuit interrupted
  output logic analog_done_n, // analog measurement finished
  output logic measure_done_n, // results valid
  output logic [7:0] keys_accepted // keys passed to the front panel logic
);
  // the connector has exactly nine sort lines and ten sweep points
  generate
    if (NUM_BINS != `SH_NUM_BINS || NUM_POINTS != `SH_NUM_POINTS) begin : g_bad_count
      $error("sorting_handler_output_logic: line count is fixed by the connector");
    end
  endgenerate

  logic [NUM_POINTS-1:0] point_fail_ff;
  logic [NUM_POINTS-1:0] nxt_point_fail;
  logic is_sweep;
  logic sweep_end;
  logic bin_update;
  logic sweep_update;

  assign is_sweep = (mode != MODE_BIN);
  assign sweep_end = result_valid && last_point;
  // same pins, two meanings: the mode picks which result reaches them [R9]
  assign bin_update = !is_sweep && result_valid;
  // sweep lines move once per list, never point by point [R12]
  assign sweep_update = is_sweep && sweep_end;

  // per-point fail flags of the running sweep
  always_comb begin
    nxt_point_fail = point_fail_ff;
    if (meas_start) begin
      nxt_point_fail = '0;
    end
    // an index past the last point is dropped rather than folded onto a real line
    if (result_valid && point_index < `SH_POINT_W'(NUM_POINTS)) begin
      nxt_point_fail[point_index] = point_fail;
    end
  end

  // fail flags gather privately so the lines only move at sweep end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      point_fail_ff <= '0;
    end else begin
      point_fail_ff <= nxt_point_fail;
    end
  end

  // sort, out and aux lines hold between updates [R17]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sort_line_n <= {NUM_BINS{`SH_LINE_IDLE}};
      out_line_n <= `SH_LINE_IDLE;
      aux_line_n <= `SH_LINE_IDLE;
    end else if (bin_update) begin // [R9]
      sort_line_n <= ~bin_hit; // [R1]
      out_line_n <= ~bin_out; // [R1]
      aux_line_n <= ~bin_aux; // [R1]
    end else if (sweep_update) begin // [R12] [R9]
      // the final point is read from nxt_point_fail: its flag is not registered yet
      sort_line_n <= ~nxt_point_fail[NUM_BINS-1:0]; // [R10] [R11]
      out_line_n <= ~nxt_point_fail[NUM_POINTS-1]; // [R11]
      aux_line_n <= ~(|nxt_point_fail); // [R10]
    end
  end

  // limit lines: only meaningful in bin mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      primary_high_n <= `SH_LINE_IDLE;
      primary_low_n <= `SH_LINE_IDLE;
      secondary_reject_n <= `SH_LINE_IDLE;
    end else if (bin_update) begin // [R9]
      primary_high_n <= ~primary_above; // [R2] [R1]
      primary_low_n <= ~primary_below; // [R2] [R1]
      secondary_reject_n <= ~(secondary_above || secondary_below); // [R3] [R1]
    end else if (sweep_update) begin
      // a sweep result has no limit judgment, so a stale bin reject must not linger
      primary_high_n <= `SH_LINE_IDLE;
      primary_low_n <= `SH_LINE_IDLE;
      secondary_reject_n <= `SH_LINE_IDLE;
    end
  end

  // analog done strobe level, cleared at next start
  // start wins over a done in the same cycle: a stale done must not release the next part
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      analog_done_n <= `SH_LINE_IDLE;
    end else if (meas_start) begin
      analog_done_n <= `SH_LINE_IDLE; // [R17]
    end else if (analog_done) begin
      case (mode)
        MODE_BIN: begin
          analog_done_n <= `SH_LINE_ACTIVE; // [R6]
        end
        MODE_SWEEP_SEQ: begin
          // the part may only be swapped once the whole list has been measured
          if (last_point) begin
            analog_done_n <= `SH_LINE_ACTIVE; // [R13]
          end
        end
        MODE_SWEEP_STEP: begin
          analog_done_n <= `SH_LINE_ACTIVE; // [R15]
        end
        default: begin
          analog_done_n <= analog_done_n;
        end
      endcase
    end
  end

  // measure done comes with the lines in bin and sequential mode; stepped mode asserts it at the first point, before the lines move
  // limitation: the strobe is a held level, so stepped mode shows one falling edge per list
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      measure_done_n <= `SH_LINE_IDLE;
    end else if (meas_start) begin
      measure_done_n <= `SH_LINE_IDLE; // [R17]
    end else if (result_valid) begin
      case (mode)
        MODE_BIN: begin
          measure_done_n <= `SH_LINE_ACTIVE; // [R8]
        end
        MODE_SWEEP_SEQ: begin
          // earlier points are valid but the list result is not
          if (last_point) begin
            measure_done_n <= `SH_LINE_ACTIVE; // [R14]
          end
        end
        MODE_SWEEP_STEP: begin
          measure_done_n <= `SH_LINE_ACTIVE; // [R16]
        end
        default: begin
          measure_done_n <= measure_done_n;
        end
      endcase
    end
  end

  // alarm follows the open-circuit detector with one cycle of delay
  // registered so the pin never shows a combinational glitch
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      alarm_n <= `SH_LINE_IDLE;
    end else begin
      alarm_n <= ~circuit_open; // [R5] [R1]
    end
  end

  // key lock: a locked panel passes no key at all, not even a held one
  // the lock input is level sensitive, so a key held across unlock shows up on the next clock edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      keys_accepted <= '0;
    end else begin
      keys_accepted <= key_lock_n ? panel_keys : 8'h00; // [R4]
    end
  end
endmodule
